// file: logic/fault_switch_pkg.sv
// Register map and reset values of the pin override stage.
package fault_switch_pkg;
	localparam int LINE_COUNT = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] DIRECTION_REG_OFFSET = 8'h03;
	localparam logic [7:0] DRIVE_VALUE_REG_OFFSET = 8'h04;
	localparam logic [7:0] DIRECTION_REG_RESET = 8'h00;
	localparam logic [7:0] DRIVE_VALUE_REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
endpackage

// file: logic/pin_override_mux.sv
// Per-line selection between the internal signal and the override setting.
module pin_override_mux #(
	parameter int LINES = 8
) (
	input wire logic [LINES-1:0] pinOverrideEnable,
	input wire logic [LINES-1:0] pinOverrideDirection,
	input wire logic [LINES-1:0] pinOverrideLevel,
	input wire logic [LINES-1:0] faultSwitchOutLine,
	output logic [LINES-1:0] lineLevel,
	output logic [LINES-1:0] lineDrive
);
	genvar i;
	generate
		for (i = 0; i < LINES; i++) begin : gLine
			always_comb begin
				if (pinOverrideEnable[i]) begin
					lineDrive[i] = pinOverrideDirection[i];
					// Level is parked low while released, value bit is kept
					lineLevel[i] = pinOverrideDirection[i] &
						pinOverrideLevel[i];
				end else begin
					lineDrive[i] = 1'b1;
					lineLevel[i] = faultSwitchOutLine[i];
				end
			end
		end
	endgenerate
endmodule

// file: logic/fault_output_pin_override.sv
// Override registers and registered pin stage for the fault switch outputs.

////////////////////////////////////////////////////////////////////////////
module fault_output_pin_override #(
	parameter int LINES = fault_switch_pkg::LINE_COUNT,
	parameter int AW = fault_switch_pkg::ADDR_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [AW-1:0] regAddr,
	input wire logic [LINES-1:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [LINES-1:0] regReadData,
	input wire logic [LINES-1:0] pinOverrideEnable,
	input wire logic [LINES-1:0] faultSwitchOutLine,
	output logic [LINES-1:0] pinOut,
	output logic [LINES-1:0] pinOutEnable
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [LINES-1:0] directionReg;
		logic [LINES-1:0] driveValueReg;
		logic [LINES-1:0] readData;
		logic [LINES-1:0] padLevel;
		logic [LINES-1:0] padDrive;
	} state_t;

	state_t state;
	state_t next_state;
	logic [LINES-1:0] lineLevel;
	logic [LINES-1:0] lineDrive;

	function automatic logic hits(input logic [AW-1:0] a,
			input logic [7:0] offset);
		hits = (a == AW'(offset));
	endfunction

	////////////////////////////////////////////////////////////////////////
	pin_override_mux #(
		.LINES(LINES)
	) overrideMux (
		.pinOverrideEnable(pinOverrideEnable),
		.pinOverrideDirection(state.directionReg),
		.pinOverrideLevel(state.driveValueReg),
		.faultSwitchOutLine(faultSwitchOutLine),
		.lineLevel(lineLevel),
		.lineDrive(lineDrive)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		// Full-width writes; every bit is independent of the others
		if (regWrite && hits(regAddr,
				fault_switch_pkg::DIRECTION_REG_OFFSET)) begin
			next_state.directionReg = regWriteData;
		end
		if (regWrite && hits(regAddr,
				fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)) begin
			next_state.driveValueReg = regWriteData;
		end
		// Read data stands only in the cycle after the strobe
		next_state.readData = '0;
		if (regRead) begin
			if (hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)) begin
				next_state.readData = state.directionReg;
			end else if (hits(regAddr,
					fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)) begin
				next_state.readData = state.driveValueReg;
			end else begin
				next_state.readData =
					LINES'(fault_switch_pkg::UNMAPPED_READ_VALUE);
			end
		end
		// Registering the pins costs one cycle but keeps them glitch free
		next_state.padLevel = lineLevel;
		next_state.padDrive = lineDrive;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state.directionReg <=
				LINES'(fault_switch_pkg::DIRECTION_REG_RESET);
			state.driveValueReg <=
				LINES'(fault_switch_pkg::DRIVE_VALUE_REG_RESET);
			state.readData <= '0;
			state.padLevel <= '0;
			state.padDrive <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign regReadData = state.readData;
	assign pinOut = state.padLevel;
	assign pinOutEnable = state.padDrive;

	////////////////////////////////////////////////////////////////////////
	// A check that starts at the release edge would still see the pads in
	// reset, so the pin checks begin once reset is low at a sampling edge.

	dirReset_a: assert property (
		@(posedge clk) $fell(sys_rst) |-> state.directionReg == '0)
		else $error("direction bits not cleared by reset");

	valReset_a: assert property (
		@(posedge clk) $fell(sys_rst) |-> state.driveValueReg == '0)
		else $error("value bits not cleared by reset");

	padReset_a: assert property (
		@(posedge clk) $fell(sys_rst) |->
		pinOut == '0 && pinOutEnable == '0)
		else $error("pins not parked by reset");

	dirWrite_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regWrite && hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)
		|=> state.directionReg == $past(regWriteData))
		else $error("direction write did not land");

	dirRead_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regRead && hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)
		|=> regReadData == $past(state.directionReg))
		else $error("direction register read data wrong");

	dirReadNew_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regWrite && hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)
		##1 regRead &&
		hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)
		|=> regReadData == $past(regWriteData, 2))
		else $error("read after write misses the new direction");

	dirKept_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(regWrite && hits(regAddr,
			fault_switch_pkg::DIRECTION_REG_OFFSET))
		|=> $stable(state.directionReg))
		else $error("direction changed without a write to it");

	valWrite_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regWrite && hits(regAddr, fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)
		|=> state.driveValueReg == $past(regWriteData))
		else $error("value write did not land");

	valRead_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regRead && hits(regAddr, fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)
		|=> regReadData == $past(state.driveValueReg) ##1
		regReadData == '0 || $past(regRead))
		else $error("value register read data wrong");

	valReadNew_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regWrite && hits(regAddr, fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)
		##1 regRead &&
		hits(regAddr, fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)
		|=> regReadData == $past(regWriteData, 2))
		else $error("read after write misses the new value");

	valKept_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(regWrite && hits(regAddr,
			fault_switch_pkg::DRIVE_VALUE_REG_OFFSET))
		|=> $stable(state.driveValueReg))
		else $error("value changed without a write to it");

	// Read data must not linger, or a stale value could pass as a read
	readIdle_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!regRead |=> regReadData == '0)
		else $error("read data lingers outside a read");

	unmappedRead_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		regRead && !hits(regAddr, fault_switch_pkg::DIRECTION_REG_OFFSET)
		&& !hits(regAddr, fault_switch_pkg::DRIVE_VALUE_REG_OFFSET)
		|=> regReadData == LINES'(fault_switch_pkg::UNMAPPED_READ_VALUE))
		else $error("unmapped read returned data");

	////////////////////////////////////////////////////////////////////////
	// Pin stage: one cycle behind the registers and the inputs

	pinReleased_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> (pinOutEnable & $past(pinOverrideEnable &
			~state.directionReg)) == '0)
		else $error("released line still driven");

	pinDriven_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> (~pinOutEnable & $past(pinOverrideEnable &
			state.directionReg)) == '0)
		else $error("overridden output line not driven");

	overrideLevel_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> ((pinOut ^ $past(state.driveValueReg)) &
			$past(pinOverrideEnable & state.directionReg)) == '0)
		else $error("driven level differs from value bit");

	bypassLine_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> ((pinOut ^ $past(faultSwitchOutLine)) &
			~$past(pinOverrideEnable)) == '0 &&
		(~pinOutEnable & ~$past(pinOverrideEnable)) == '0)
		else $error("bypassed line does not follow internal signal");

	valueIgnored_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!sys_rst |=> (pinOut & $past(pinOverrideEnable &
			~state.directionReg)) == '0)
		else $error("value bit leaks onto a released line");

endmodule

// file: tb/pin_pad_model.sv
// Far-side pad model for the eight override output lines.
module pin_pad_model (
	input wire logic clk,
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOutEnable,
	output logic [7:0] padLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lastLevel = 8'h00;
	// No pull on the pads: a released line toggles so it never looks held
	always_comb begin
		padLevel = (pinOutEnable & pinOut) | (~pinOutEnable & ~lastLevel);
	end
	always_ff @(posedge clk) begin
		lastLevel <= padLevel;
	end
endmodule

// file: tb/fault_output_pin_override_test.sv
// Self-checking bench for the fault output pin override stage.
module fault_output_pin_override_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWriteData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] pinOverrideEnable = 8'h00;
	logic [7:0] faultSwitchOutLine = 8'h00;
	logic [7:0] regReadData, pinOut, pinOutEnable, padLevel;
	logic [7:0] d, v, e, f;
	integer seed = 32'h60772512;
	int mismatches = 0;
	int n_tests = 0;
	fault_output_pin_override fault_output_pin_override_inst (.clk(clk),
		.sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
		.pinOverrideEnable(pinOverrideEnable),
		.faultSwitchOutLine(faultSwitchOutLine),
		.pinOut(pinOut), .pinOutEnable(pinOutEnable));
	pin_pad_model pin_pad_model_inst (.clk(clk), .pinOut(pinOut),
		.pinOutEnable(pinOutEnable), .padLevel(padLevel));
	initial begin
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= dat;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regReadData, exp);
		@(posedge clk);
		#1 chk(regReadData, 8'h00);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWriteData <= dat;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regReadData, dat);
	endtask
	function automatic logic [7:0] expOe(input logic [7:0] en, dir);
		return ~en | dir;
	endfunction
	function automatic logic [7:0] expOut(input logic [7:0] en, dir, val, sig);
		return (~en & sig) | (en & dir & val);
	endfunction
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h07, 8'h00);
		// Strobes with no gap: the read right after a write sees it
		wr_rd(8'h03, 8'ha5);
		wr_rd(8'h04, 8'h5a);
		$display("reset values done");
		for (int i = 0; i < 40; i++) begin
			d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			v = (i < 2) ? ~d : 8'($random(seed));
			e = (i < 2) ? 8'hff : 8'($random(seed));
			f = 8'($random(seed));
			wr(8'h03, d);
			wr(8'h04, v);
			wr(8'h05, ~d);
			rd(8'h03, d);
			rd(8'h04, v);
			@(posedge clk);
			pinOverrideEnable <= e;
			faultSwitchOutLine <= f;
			repeat (2) @(posedge clk);
			#1 chk(pinOutEnable, expOe(e, d));
			chk(pinOut, expOut(e, d, v, f));
			chk(padLevel & pinOutEnable,
				expOut(e, d, v, f) & expOe(e, d));
		end
		$display("pin override tests done");
		// All-ones values written after the loop must be cleared by a reset in mid-run
		wr(8'h03, 8'hff);
		wr(8'h04, 8'hff);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk(pinOutEnable, 8'h00);
		chk(pinOut, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		chk(pinOutEnable, expOe(e, 8'h00));
		chk(pinOut, expOut(e, 8'h00, 8'h00, f));
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule
